//--- smsp_peer.sv
`timescale 1ns/1ps
// far-end spi party: slave to a master device, master to a slave one
module smsp_peer (
  input  wire logic clock,
  input  wire logic cpol,
  input  wire logic cke,
  input  wire logic sck_line,
  input  wire logic sdo_line,
  output logic      sck_gen,
  output logic      ss_n,
  output logic      sdi
);
  logic [7:0] tx    = 8'h00; // word sent out
  logic [7:0] rx    = 8'h00; // word caught
  logic [3:0] oidx  = 4'h8;  // next bit to present
  logic       sck_q = 1'h0;  // clock level one cycle ago
  logic       flip  = 1'h0;  // clock away from idle
  // idle level follows polarity, so no stray edge between frames
  assign sck_gen = cpol ^ flip;
  initial begin
    ss_n = 1'h1;
    sdi = 1'h0;
  end
  // start a word; with data leading the clock the msb goes out at once
  task automatic load(input logic [7:0] w);
    tx <= w;
    oidx <= cke ? 4'h1 : 4'h0;
    if (cke) sdi <= w[7];
  endtask
  // edges found in own clock domain; sample and shift on opposite edges
  always @(posedge clock) begin
    sck_q <= sck_line;
    if (sck_line != sck_q) begin
      if ((sck_line != cpol) == cke) begin
        rx <= {rx[6:0], sdo_line};
      end else if (oidx < 4'h8) begin
        sdi <= tx[3'h7 - oidx[2:0]];
        oidx <= oidx + 4'h1;
      end else begin
        sdi <= ~sdi; // word over: no stale bit left on the line
      end
    end
  end
  // master role: 16 edges at the 48 ns link rate, select held low
  task automatic run_master();
    ss_n <= 1'h0;
    repeat (6) @(posedge clock);
    repeat (16) begin
      flip <= ~flip;
      repeat (6) @(posedge clock);
    end
    ss_n <= 1'h1;
  endtask
endmodule

//--- smsp_pkg.sv
package smsp_pkg;
  // avalon byte offsets, one word each
  localparam logic [4:0] OFF_STATUS   = 5'h00;
  localparam logic [4:0] OFF_CONTROL  = 5'h04;
  localparam logic [4:0] OFF_BUFFER   = 5'h08;
  localparam logic [4:0] OFF_IRQ_ST   = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
  // status field positions
  localparam int STAT_SMP  = 7;
  localparam int STAT_CKE  = 6;
  localparam int STAT_STOP = 4;
  localparam int STAT_BF   = 0;
  // irq status / mask bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WRITE_COLLISION_FLAG = 1;
  localparam int IRQ_OVF  = 2;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] BUFFER_RST  = 8'h00;
  localparam logic [2:0] MASK_RST    = 3'h0;
  // mode select encodings
  localparam logic [3:0] MODE_DIV4   = 4'h0;
  localparam logic [3:0] MODE_DIV16  = 4'h1;
  localparam logic [3:0] MODE_DIV64  = 4'h2;
  localparam logic [3:0] MODE_TIMER2_OUTPUT   = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV_NS = 4'h5;
  // master half periods of the serial clock, in clock cycles
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  // bit and tick counts of one word
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [4:0] SCK_EDGES = 5'h10;
  localparam logic [4:0] END_TICK  = 5'h11;
  // control register layout
  typedef struct packed {
    logic       write_collision_flag;
    logic       ovf;
    logic       en;
    logic       clock_idle_polarity;
    logic [3:0] mode;
  } smsp_ctl_s;
  // master clock engine
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} smsp_state_e;
endpackage

//--- smsp_top.sv
`timescale 1ns/1ps
// Functional notes
// - one 8-bit word, full duplex per transfer
// - all four polarity and edge combinations
// - data out, data in, clock; select
// - full byte copied to buffer, flag set
// - buffer write loads buffer and shifter
// - shifter reached only through the buffer
// - status top two bits writable, rest read-only
// - sample phase: end or middle, master
// - edge select picks the transmit edge
// - buffer full flag tracks received word
// - stop-seen bit cleared when port disabled
// - two-wire status bits unused here
// - mode field picks clock source, slave
// - polarity bit sets serial clock idle
// - busy write ignored, collision flag sticks
// - shift most significant bit first
module smsp_top #(
  parameter int WORD_W = 8
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        timer2_output,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_n,
  input  wire logic        ss_n_in,
  output logic             irq
);
  // the shifter and counters are built for bytes only
  if (WORD_W != 8) begin : g_chk
    $error("WORD_W must be 8");
  end

  logic               rst_m_ff;    // reset release stage 1
  logic               rst_s_n;     // released reset copy
  logic               sck_m_ff;    // pin sync stage 1
  logic               sck_s_ff;    // pin sync stage 2
  logic               sck_d_ff;    // previous synced clock
  logic               sdi_m_ff;
  logic               sdi_s_ff;
  logic               ss_m_ff;
  logic               ss_s_ff;     // synced select, low active
  smsp_pkg::smsp_ctl_s ctl_ff;     // control register
  logic               smp_ff;      // input sample phase
  logic               cke_ff;      // clock edge select
  logic               stop_ff;     // stop-seen, never set here
  logic               bf_ff;       // buffer full flag
  logic [7:0]         buf_ff;      // serial buffer
  logic [7:0]         sr_ff;       // serial shift register
  logic [3:0]         bit_cnt_ff;  // bits sampled so far
  logic [4:0]         tick_ff;     // master ticks done
  logic [5:0]         div_ff;      // master rate divider
  smsp_pkg::smsp_state_e state_ff;
  logic [2:0]         irq_st_ff;   // sticky events
  logic [2:0]         irq_mask_ff; // event enables
  logic [31:0]        nxt_rdata;
  logic [7:0]         nxt_word;    // shifter plus incoming bit
  logic [5:0]         half;
  logic [4:0]         tcur;        // number of the pending tick

  // reset: asynchronous assert, two-flop release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_ff <= 1'b0;
      rst_s_n  <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_s_n  <= rst_m_ff;
    end
  end

  // pin synchronisers; stage 1 feeds stage 2 only
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sck_m_ff <= 1'b0;
      sck_s_ff <= 1'b0;
      sck_d_ff <= 1'b0;
      sdi_m_ff <= 1'b0;
      sdi_s_ff <= 1'b0;
      ss_m_ff  <= 1'b1;
      ss_s_ff  <= 1'b1;
    end else begin
      sck_m_ff <= sck_in;
      sck_s_ff <= sck_m_ff;
      sck_d_ff <= sck_s_ff;
      sdi_m_ff <= sdi_in;
      sdi_s_ff <= sdi_m_ff;
      ss_m_ff  <= ss_n_in;
      ss_s_ff  <= ss_m_ff;
    end
  end

  // decode of bus, mode and link events
  wire acc     = (read | write) & ~waitrequest;
  wire wr      = acc & write & byteenable[0];
  wire rd      = acc & read;
  wire wr_stat = wr & (address == smsp_pkg::OFF_STATUS);
  wire wr_ctl  = wr & (address == smsp_pkg::OFF_CONTROL);
  wire wr_buf  = wr & (address == smsp_pkg::OFF_BUFFER);
  wire wr_ist  = wr & (address == smsp_pkg::OFF_IRQ_ST);
  wire wr_msk  = wr & (address == smsp_pkg::OFF_IRQ_MASK);
  wire rd_buf  = rd & (address == smsp_pkg::OFF_BUFFER);
  wire master  = (ctl_ff.mode[3:2] == 2'b00);
  wire slave   = (ctl_ff.mode == smsp_pkg::MODE_SLV_SS) |
                 (ctl_ff.mode == smsp_pkg::MODE_SLV_NS);
  wire active  = ctl_ff.en & (master | slave);
  // select high abandons a slave word in MODE_SLV_SS only
  wire ss_off  = (ctl_ff.mode == smsp_pkg::MODE_SLV_SS) & ss_s_ff;
  wire slv_go  = active & slave & ~ss_off;
  wire run     = (state_ff == smsp_pkg::ST_RUN);
  wire busy    = run | (bit_cnt_ff != 4'h0);
  // collision flag also holds off further loads
  wire load    = wr_buf & ~busy & ~ctl_ff.write_collision_flag;
  wire collide = wr_buf & busy;
  wire s_edge  = sck_s_ff ^ sck_d_ff;
  wire s_lead  = s_edge & (sck_s_ff != ctl_ff.clock_idle_polarity);
  wire s_trail = s_edge & (sck_s_ff == ctl_ff.clock_idle_polarity);
  wire m_tick  = run & ((ctl_ff.mode == smsp_pkg::MODE_TIMER2_OUTPUT) ?
                 timer2_output : (div_ff == half - 6'h01));
  wire m_odd   = m_tick & tcur[0];
  wire m_even  = m_tick & ~tcur[0];
  wire m_sck   = tcur <= smsp_pkg::SCK_EDGES;
  // late sampling needs one tick past the last edge
  wire m_s_ok  = (tcur <= (smp_ff ? smsp_pkg::END_TICK : smsp_pkg::SCK_EDGES)) &
                 ~(smp_ff & (tcur == 5'h01));
  wire sample  = master ?
                 (active & ((cke_ff ^ smp_ff) ? m_odd : m_even) & m_s_ok) :
                 (slv_go & (cke_ff ? s_lead : s_trail));
  wire xmit    = master ? (active & (cke_ff ? m_even : m_odd) & m_sck) :
                 (slv_go & (cke_ff ? s_trail : s_lead));
  wire done    = sample & (bit_cnt_ff == smsp_pkg::LAST_BIT);
  // slave word lost when the buffer is still unread
  wire ovf_set = done & slave & bf_ff & ~rd_buf;

  assign tcur     = tick_ff + 5'h01;
  assign nxt_word = {sr_ff[6:0], sdi_s_ff};

  // master half period from the mode field
  always_comb begin
    unique case (ctl_ff.mode)
      smsp_pkg::MODE_DIV16: half = smsp_pkg::HALF_DIV16;
      smsp_pkg::MODE_DIV64: half = smsp_pkg::HALF_DIV64;
      default:              half = smsp_pkg::HALF_DIV4;
    endcase
  end

  // control register; hardware set wins over clear
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ctl_ff <= smsp_pkg::CONTROL_RST;
    end else begin
      if (wr_ctl) begin
        ctl_ff <= writedata[7:0];
      end
      if (collide) begin
        ctl_ff.write_collision_flag <= 1'b1;
      end
      if (ovf_set) begin
        ctl_ff.ovf <= 1'b1;
      end
    end
  end

  // status: only the top two bits take writes
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      smp_ff  <= 1'b0;
      cke_ff  <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      if (wr_stat) begin
        smp_ff <= writedata[smsp_pkg::STAT_SMP];
        cke_ff <= writedata[smsp_pkg::STAT_CKE];
      end
      if (!ctl_ff.en) begin
        stop_ff <= 1'b0;
      end
    end
  end

  // buffer full: set by a word, cleared by a buffer read
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      bf_ff <= 1'b0;
    end else if (done & ~ovf_set) begin
      bf_ff <= 1'b1;
    end else if (rd_buf) begin
      bf_ff <= 1'b0;
    end
  end

  // shift engine: one shifter for both directions
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sr_ff      <= smsp_pkg::BUFFER_RST;
      buf_ff     <= smsp_pkg::BUFFER_RST;
      bit_cnt_ff <= 4'h0;
      sdo_out    <= 1'b0;
    end else if (load) begin
      sr_ff  <= writedata[7:0];
      buf_ff <= writedata[7:0];
      if (cke_ff) begin
        sdo_out <= writedata[7];
      end
    end else if (!active || ss_off) begin
      bit_cnt_ff <= 4'h0;
    end else begin
      if (sample) begin
        sr_ff      <= nxt_word;
        bit_cnt_ff <= done ? 4'h0 : bit_cnt_ff + 4'h1;
        if (done && !ovf_set) begin
          buf_ff <= nxt_word;
        end
      end
      // a shift in the same tick already moved the next bit up
      if (xmit) begin
        sdo_out <= sample ? sr_ff[6] : sr_ff[7];
      end
    end
  end

  // master engine: 16 clock edges plus one late-sample tick
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_ff <= smsp_pkg::ST_IDLE;
      tick_ff  <= 5'h00;
      div_ff   <= 6'h00;
    end else if (!active) begin
      state_ff <= smsp_pkg::ST_IDLE;
      tick_ff  <= 5'h00;
      div_ff   <= 6'h00;
    end else if (load && master) begin
      state_ff <= smsp_pkg::ST_RUN;
      tick_ff  <= 5'h00;
      div_ff   <= 6'h00;
    end else if (run) begin
      if (m_tick) begin
        div_ff  <= 6'h00;
        tick_ff <= tcur;
        if (tcur == smsp_pkg::END_TICK) begin
          state_ff <= smsp_pkg::ST_IDLE;
        end
      end else begin
        div_ff <= div_ff + 6'h01;
      end
    end
  end

  // serial clock out: idles at the polarity level
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sck_out <= 1'b0;
    end else if (m_tick && m_sck) begin
      sck_out <= ~sck_out;
    end else if (!run) begin
      sck_out <= ctl_ff.clock_idle_polarity;
    end
  end

  // pin drivers; enables low while driving
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sck_oe_n <= 1'b1;
      sdo_oe_n <= 1'b1;
    end else begin
      sck_oe_n <= ~(active & master);
      sdo_oe_n <= ~(active & (master | ~ss_off));
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      irq_st_ff   <= 3'h0;
      irq_mask_ff <= smsp_pkg::MASK_RST;
      irq         <= 1'b0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~(wr_ist ? writedata[2:0] : 3'h0)) |
                   {ovf_set, collide, done};
      if (wr_msk) begin
        irq_mask_ff <= writedata[2:0];
      end
      irq <= |(irq_st_ff & irq_mask_ff);
    end
  end

  // read mux; the two-wire status bits read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (address)
      smsp_pkg::OFF_STATUS:   nxt_rdata[7:0] = {smp_ff, cke_ff, 1'b0, stop_ff, 3'h0, bf_ff};
      smsp_pkg::OFF_CONTROL:  nxt_rdata[7:0] = ctl_ff;
      smsp_pkg::OFF_BUFFER:   nxt_rdata[7:0] = buf_ff;
      smsp_pkg::OFF_IRQ_ST:   nxt_rdata[2:0] = irq_st_ff;
      smsp_pkg::OFF_IRQ_MASK: nxt_rdata[2:0] = irq_mask_ff;
      default:                nxt_rdata = 32'h0000_0000;
    endcase
  end

  // avalon slave: waitrequest drops one cycle after a request
  always_ff @(posedge clock or negedge rst_s_n) begin
    if (!rst_s_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read && waitrequest) begin
        readdata <= nxt_rdata;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_s_n);

  sequence s_last;
    run && m_tick && (tcur == smsp_pkg::END_TICK);
  endsequence
  sequence s_quiet;
    !run && $stable(ctl_ff.clock_idle_polarity);
  endsequence

  bus_answer_a: assert property ((read | write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  word_end_a: assert property (s_last |=> !run && (bit_cnt_ff == 4'h0))
    else $error("master word did not end cleanly");
  word_copy_a: assert property (done && !ovf_set |=> bf_ff && (buf_ff == $past(nxt_word)))
    else $error("received byte not copied to buffer");
  load_both_a: assert property (load |=> (sr_ff == buf_ff) && busy == master)
    else $error("buffer write did not load shifter");
  status_ro_a: assert property (wr_stat && !done && !rd_buf |=> bf_ff == $past(bf_ff))
    else $error("status low bits took a write");
  sample_phase_a: assert property (master && sample |-> tcur[0] == (cke_ff ^ smp_ff))
    else $error("master sampled on wrong tick");
  xmit_edge_a: assert property (master && xmit |-> tcur[0] == !cke_ff)
    else $error("master transmitted on wrong edge");
  bf_clear_a: assert property (rd_buf && !done |=> !bf_ff)
    else $error("buffer read left full flag set");
  stop_clear_a: assert property (!ctl_ff.en |=> !stop_ff)
    else $error("stop bit set while disabled");
  idle_level_a: assert property (s_quiet ##1 s_quiet |-> sck_out == ctl_ff.clock_idle_polarity)
    else $error("serial clock not at idle level");
  write_collision_flag_hold_a: assert property (collide && !done |=> ctl_ff.write_collision_flag && (buf_ff == $past(buf_ff)))
    else $error("busy write not ignored");
  msb_out_a: assert property (load && cke_ff |=> sdo_out == buf_ff[7])
    else $error("first bit out is not the msb");
  abandon_a: assert property (!active |=> (bit_cnt_ff == 4'h0) && !run)
    else $error("disable did not abandon transfer");
  irq_out_a: assert property (|(irq_st_ff & irq_mask_ff) |=> irq)
    else $error("unmasked event did not raise irq");
endmodule

//--- spi_mode_serial_port_tb.sv
`timescale 1ns/1ps
// register access, master words in all modes, slave words, faults
module spi_mode_serial_port_tb;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata, q;
  logic        waitrequest, sck_out, sck_oe_n, sdo_out, sdo_oe_n, irq;
  logic        sck_gen, ss_n, sdi;
  logic        timer2_output = 1'h0;
  logic [2:0]  t2_cnt = 3'h0; // timer tick divider
  logic        sdo_q = 1'h0;  // last data line level
  logic        sck_q = 1'h0;  // last master clock level
  logic        cpol = 1'h0;
  logic        cke = 1'h0;
  int          edges = 0;     // master clock toggles
  int          n_mismatch = 0;
  int          checks_done = 0;
  // shared clock wire; a released data line shows its last level inverted
  wire sck_line = sck_oe_n ? sck_gen : sck_out;
  wire sdo_line = sdo_oe_n ? ~sdo_q : sdo_out;
  always #2 clock = ~clock;
  smsp_top smsp_top_i (.clock, .rst_n, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .timer2_output, .sck_in(sck_line), .sck_out, .sck_oe_n,
    .sdi_in(sdi), .sdo_out, .sdo_oe_n, .ss_n_in(ss_n), .irq);
  smsp_peer smsp_peer_i (.clock, .cpol, .cke, .sck_line, .sdo_line, .sck_gen, .ss_n, .sdi);
  // timer tick every 8 cycles; clock toggles counted one cycle late
  always @(posedge clock) begin
    t2_cnt <= t2_cnt + 3'h1;
    timer2_output <= (t2_cnt == 3'h7);
    sdo_q <= sdo_line;
    sck_q <= sck_out;
    if (sck_q != sck_out) edges++;
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon cycle held until waitrequest low; data taken at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h000000, d};
    write <= w;
    read <= ~w;
    @(posedge clock);
    while (waitrequest !== 1'h0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n == 50) n_mismatch++;
    q = readdata;
    write <= 1'h0;
    read <= 1'h0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00);
    check(q, e);
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
  endtask
  // bounded wait for the level interrupt
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 5000) begin
      @(posedge clock);
      n++;
    end
    if (n == 5000) n_mismatch++;
  endtask
  // one master word with random data both ways
  task automatic master(input logic [3:0] m, input logic p, input logic e);
    logic [7:0] t, r;
    logic s;
    t = $urandom;
    r = $urandom;
    s = $urandom;
    cpol = p;
    cke = e;
    wr(smsp_pkg::OFF_STATUS, {s, e, 6'h00});
    wr(smsp_pkg::OFF_CONTROL, {3'h1, p, m});
    settle();
    check(sck_out, p);
    check(sck_oe_n, 1'h0);
    smsp_peer_i.load(r);
    edges = 0;
    wr(smsp_pkg::OFF_BUFFER, t);
    wait_irq();
    // the word is done at its last sample, which can fall before the
    // final clock edge; let the slowest rate finish before counting
    repeat (70) @(posedge clock);
    check(edges, 16);
    check(smsp_peer_i.rx, t);
    rd(smsp_pkg::OFF_STATUS, {s, e, 6'h01});
    bus(1'h0, smsp_pkg::OFF_BUFFER, 8'h00);
    if (m != smsp_pkg::MODE_DIV4) check(q, r);
    rd(smsp_pkg::OFF_STATUS, {s, e, 6'h00});
    wr(smsp_pkg::OFF_IRQ_ST, 8'h07);
  endtask
  // one slave word, the peer making the clock
  task automatic slave(input logic [3:0] m, input logic e);
    logic [7:0] t, r;
    t = $urandom;
    r = $urandom;
    wr(smsp_pkg::OFF_CONTROL, 8'h00);
    cpol = $urandom;
    cke = e;
    wr(smsp_pkg::OFF_STATUS, {1'h0, e, 6'h00});
    wr(smsp_pkg::OFF_CONTROL, {3'h1, cpol, m});
    settle();
    check(sck_oe_n, 1'h1);
    smsp_peer_i.load(r);
    wr(smsp_pkg::OFF_BUFFER, t);
    smsp_peer_i.run_master();
    wait_irq();
    check(smsp_peer_i.rx, t);
    rd(smsp_pkg::OFF_BUFFER, r);
    wr(smsp_pkg::OFF_IRQ_ST, 8'h07);
  endtask
  initial begin
    void'($urandom(5));
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    repeat (3) @(posedge clock);
    rd(smsp_pkg::OFF_STATUS, 32'h0);
    rd(smsp_pkg::OFF_CONTROL, 32'h0);
    rd(smsp_pkg::OFF_BUFFER, 32'h0);
    rd(smsp_pkg::OFF_IRQ_MASK, 32'h0);
    rd(5'h14, 32'h0);
    wr(smsp_pkg::OFF_STATUS, 8'hFF);
    rd(smsp_pkg::OFF_STATUS, 32'hC0);
    wr(smsp_pkg::OFF_IRQ_MASK, 8'h01);
    for (int i = 0; i < 16; i++) begin
      master(4'(i >> 2), i[1], i[0]);
    end
    // second load in mid word: ignored, collision flag sticks
    smsp_peer_i.load(8'h66);
    wr(smsp_pkg::OFF_BUFFER, 8'hA5);
    rd(smsp_pkg::OFF_BUFFER, 32'hA5);
    wr(smsp_pkg::OFF_BUFFER, 8'h3C);
    rd(smsp_pkg::OFF_CONTROL, 32'hB3);
    wait_irq();
    check(smsp_peer_i.rx, 8'hA5);
    rd(smsp_pkg::OFF_IRQ_ST, 32'h03);
    rd(smsp_pkg::OFF_BUFFER, 32'h66);
    // mask gates the level output
    wr(smsp_pkg::OFF_IRQ_MASK, 8'h00);
    settle();
    check(irq, 1'h0);
    wr(smsp_pkg::OFF_IRQ_MASK, 8'h02);
    settle();
    check(irq, 1'h1);
    wr(smsp_pkg::OFF_IRQ_ST, 8'h03);
    settle();
    check(irq, 1'h0);
    wr(smsp_pkg::OFF_IRQ_MASK, 8'h01);
    edges = 0;
    wr(smsp_pkg::OFF_BUFFER, 8'h11);
    repeat (100) @(posedge clock);
    check(edges, 0);
    byteenable <= 4'h0;
    wr(smsp_pkg::OFF_CONTROL, 8'h00);
    byteenable <= 4'hF;
    rd(smsp_pkg::OFF_CONTROL, 32'hB3);
    // disable in mid word, then a clean word
    wr(smsp_pkg::OFF_CONTROL, 8'h22);
    wr(smsp_pkg::OFF_BUFFER, 8'h5A);
    repeat (100) @(posedge clock);
    wr(smsp_pkg::OFF_CONTROL, 8'h02);
    settle();
    check(sck_oe_n, 1'h1);
    bus(1'h0, smsp_pkg::OFF_STATUS, 8'h00);
    check(q[4], 1'h0);
    master(smsp_pkg::MODE_DIV64, 1'h0, 1'h1);
    wr(smsp_pkg::OFF_CONTROL, 8'h26);
    settle();
    check({sck_oe_n, sdo_oe_n}, 2'h3);
    for (int i = 0; i < 4; i++) begin
      slave(smsp_pkg::MODE_SLV_SS | 4'(i >> 1), i[0]);
    end
    tally_and_finish();
  end
  // hang guard, well past the expected run
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
